// ---- cwl_map.svh ----
`ifndef CWL_MAP_SVH
`define CWL_MAP_SVH
// flash word addresses (program-memory word address, 24-bit)
`define CWL_ADDR_W 24
`define CWL_WORD_W 24
`define CWL_TOP_WORD_DEF 24'h00abfe
`define CWL_WORD_STEP 24'h000002
`define CWL_CFG_BASE 24'hf80000
`define CWL_CFG_SPACE_LO 24'h800000
`define CWL_CFG_SPACE_HI 24'hffffff
`define CWL_NUM_WORDS 2'h3
`define CWL_ERASED 24'hffffff
// first configuration word fields
`define CWL_UPPER_HI 23
`define CWL_UPPER_LO 16
`define CWL_RSVD15 15
`define CWL_SCAN_EN 14
`define CWL_CODE_PROT 13
`define CWL_WRITE_PROT 12
`define CWL_DEBUG_N 11
`define CWL_RSVD10 10
`define CWL_PIN_HI 9
`define CWL_PIN_LO 8
`define CWL_WDT_ON 7
`define CWL_WIN_OFF 6
`define CWL_UNIMP5 5
`define CWL_PRESCALE 4
`define CWL_POST_HI 3
`define CWL_POST_LO 0
`define CWL_ONES_MASK 24'hff0020
`define CWL_PRE_128 8'h80
`define CWL_PRE_32 8'h20
`define CWL_PIN_RSVD 2'h0
`endif

// ---- cwl_pkg.sv ----
package cwl_pkg;
  typedef enum logic [3:0] {
    CWL_IDLE = 4'h1,
    CWL_REQ = 4'h2,
    CWL_WAIT = 4'h4,
    CWL_DONE = 4'h8
  } cwl_state_t;
  typedef logic [23:0] cwl_word_t;
endpackage

// ---- cwl_word_store.sv ----
`timescale 1ns/1ps
`include "cwl_map.svh"
// three volatile configuration words, registered read
module cwl_word_store #(
  parameter int DEPTH = 3
) (
  input wire logic clk,
  input wire logic srst,
  // write side
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire cwl_pkg::cwl_word_t wr_data,
  // read side
  input wire logic [1:0] rd_idx,
  output cwl_pkg::cwl_word_t rd_data
);
  import cwl_pkg::*;
  typedef struct packed {
    cwl_word_t [DEPTH-1:0] mem;
    cwl_word_t rd;
  } cwl_store_t;
  cwl_store_t st;
  cwl_store_t next_st;
  if (DEPTH != 3) begin
    $error("depth must be three");
  end
  always_comb begin
    next_st = st;
    if (wr_en && (int'(wr_idx) < DEPTH)) begin
      next_st.mem[wr_idx] = wr_data;
    end
    next_st.rd = (int'(rd_idx) < DEPTH) ? st.mem[rd_idx] : `CWL_ERASED;
    if (srst) begin
      // volatile: back to erased until the loader refills
      for (int i = 0; i < DEPTH; i++) begin
        next_st.mem[i] = `CWL_ERASED;
      end
      next_st.rd = `CWL_ERASED;
    end
  end
  always_ff @(posedge clk) begin
    st <= next_st;
  end
  assign rd_data = st.rd;
endmodule

// ---- cwl_loader.sv ----
`timescale 1ns/1ps
`include "cwl_map.svh"
module cwl_loader #(
  parameter logic [23:0] TOP_WORD_ADDR = `CWL_TOP_WORD_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // any device reset source
  input wire logic dev_reset_req,
  // flash read port
  output logic flash_rd,
  output logic [23:0] flash_addr,
  input wire logic flash_ack,
  input wire cwl_pkg::cwl_word_t flash_data,
  // flash page erase and write path
  input wire logic page_erase_last,
  input wire logic serial_prog_path,
  // table access into configuration space
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic fetch_or_data,
  input wire logic [23:0] tbl_addr,
  input wire cwl_pkg::cwl_word_t tbl_wdata,
  output cwl_pkg::cwl_word_t tbl_rdata,
  output logic tbl_rvalid,
  output logic cfg_space_refused,
  // program memory write request
  input wire logic pm_write_req,
  output logic pm_write_grant,
  // to the device
  output logic dev_reset_hold,
  output logic config_word_one_valid,
  output cwl_pkg::cwl_word_t config_word_one,
  output logic scan_port_enable,
  output logic general_code_protect,
  output logic general_write_protect,
  output logic debug_mode_entry,
  output logic [1:0] emulator_pin_pair_select,
  output logic emulator_pin_reserved,
  output logic watchdog_on,
  output logic window_mode_off,
  output logic window_mode_active,
  output logic [7:0] watchdog_prescale_ratio,
  output logic [15:0] watchdog_postscale_ratio
);
  import cwl_pkg::*;
  typedef struct packed {
    cwl_state_t fsm;
    logic [1:0] idx;
    logic rd;
    logic [23:0] addr;
    logic hold;
    logic valid;
    cwl_word_t w1;
    cwl_word_t w2;
    cwl_word_t w3;
    logic scan;
    logic cprot;
    logic gwp;
    logic dbg;
    logic [1:0] pins;
    logic pins_bad;
    logic wdt;
    logic winoff;
    logic winact;
    logic [7:0] pre;
    logic [15:0] post;
    logic grant;
    cwl_word_t rdata;
    logic rvalid;
    logic rpend;
    logic rprot;
    logic refused;
    logic erased;
  } cwl_state_s_t;
  cwl_state_s_t st;
  cwl_state_s_t next_st;
  cwl_word_t w;
  cwl_word_t wrd;
  logic in_cfg;
  logic [1:0] tbl_idx;
  logic st_wr;
  cwl_word_t st_rd;

  // odd or too-low tops would break the step-down walk
  if (TOP_WORD_ADDR[0] != 1'b0) begin
    $error("top word address must be even");
  end
  if (TOP_WORD_ADDR < 24'h000004) begin
    $error("top word address too low");
  end

  // words kept in a registered store so table reads see loaded values
  cwl_word_store #(.DEPTH(3)) u_store (
    .clk(clk),
    .srst(srst),
    .wr_en(st_wr),
    .wr_idx(st.idx),
    .wr_data(flash_data),
    .rd_idx(tbl_idx),
    .rd_data(st_rd)
  );

  always_comb begin
    next_st = st;
    st_wr = 1'b0;
    // unimplemented bits forced to one regardless of flash contents
    w = st.w1 | `CWL_ONES_MASK;
    wrd = flash_data | `CWL_ONES_MASK;
    in_cfg = (tbl_addr >= `CWL_CFG_SPACE_LO) && (tbl_addr <= `CWL_CFG_SPACE_HI);
    tbl_idx = 2'((tbl_addr - `CWL_CFG_BASE) >> 1);
    next_st.rvalid = 1'b0;
    next_st.refused = 1'b0;
    case (st.fsm)
      CWL_IDLE: begin
        if (dev_reset_req) begin
          next_st.fsm = CWL_REQ;
          next_st.hold = 1'b1;
          next_st.valid = 1'b0;
          next_st.idx = 2'h0;
          next_st.addr = TOP_WORD_ADDR;
        end
      end
      CWL_REQ: begin
        next_st.rd = 1'b1;
        next_st.fsm = CWL_WAIT;
      end
      CWL_WAIT: begin
        if (flash_ack) begin
          next_st.rd = 1'b0;
          st_wr = 1'b1;
          case (st.idx)
            2'h0: next_st.w1 = wrd;
            2'h1: next_st.w2 = wrd;
            default: next_st.w3 = wrd;
          endcase
          if (st.idx == (`CWL_NUM_WORDS - 2'h1)) begin
            next_st.fsm = CWL_DONE;
          end else begin
            next_st.idx = st.idx + 2'h1;
            next_st.addr = st.addr - `CWL_WORD_STEP;
            next_st.fsm = CWL_REQ;
          end
        end
      end
      CWL_DONE: begin
        next_st.valid = 1'b1;
        next_st.hold = 1'b0;
        next_st.fsm = CWL_IDLE;
      end
      default: next_st.fsm = CWL_IDLE;
    endcase
    // decode of word one
    next_st.scan = w[`CWL_SCAN_EN];
    next_st.cprot = ~w[`CWL_CODE_PROT] | st.erased;
    next_st.gwp = ~w[`CWL_WRITE_PROT];
    next_st.dbg = ~w[`CWL_DEBUG_N];
    next_st.pins = w[`CWL_PIN_HI:`CWL_PIN_LO];
    next_st.pins_bad = (w[`CWL_PIN_HI:`CWL_PIN_LO] == `CWL_PIN_RSVD);
    next_st.wdt = w[`CWL_WDT_ON];
    next_st.winoff = w[`CWL_WIN_OFF];
    next_st.winact = ~w[`CWL_WIN_OFF] & w[`CWL_WDT_ON];
    next_st.pre = w[`CWL_PRESCALE] ? `CWL_PRE_128 : `CWL_PRE_32;
    next_st.post = 16'h0001 << w[`CWL_POST_HI:`CWL_POST_LO];
    next_st.grant = pm_write_req & ~next_st.gwp & ~st.hold;
    // erase of the last page sets the erased flag (words keep their values), so protection comes on
    if (page_erase_last) begin
      next_st.erased = 1'b1;
    end else if (st_wr && (st.idx == (`CWL_NUM_WORDS - 2'h1))) begin
      // cleared with the last word so protection settles as hold drops
      next_st.erased = 1'b0;
    end
    // store data is registered, so the answer leaves two cycles after the request
    next_st.rpend = 1'b0;
    if (st.rpend) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = st.rprot ? `CWL_ERASED : (st_rd | `CWL_ONES_MASK);
    end
    // table access only; fetch or data access into the range is refused
    if ((tbl_rd || tbl_wr || fetch_or_data) && in_cfg) begin
      if (fetch_or_data) begin
        next_st.refused = 1'b1;
      end else if (tbl_rd) begin
        next_st.rpend = 1'b1;
        next_st.rprot = st.cprot;
      end else if (tbl_wr && (tbl_idx == 2'h0) && !serial_prog_path) begin
        // scan-enable bit stays unless written over the serial path
        next_st.w1 = tbl_wdata;
        next_st.w1[`CWL_SCAN_EN] = st.w1[`CWL_SCAN_EN];
      end else if (tbl_wr && (tbl_idx == 2'h0)) begin
        next_st.w1 = tbl_wdata;
      end
    end
    if (srst) begin
      // erased default: every bit unprogrammed until loaded
      next_st.fsm = CWL_REQ;
      next_st.idx = 2'h0;
      next_st.rd = 1'b0;
      next_st.addr = TOP_WORD_ADDR;
      next_st.hold = 1'b1;
      next_st.valid = 1'b0;
      next_st.w1 = `CWL_ERASED;
      next_st.w2 = `CWL_ERASED;
      next_st.w3 = `CWL_ERASED;
      next_st.scan = 1'b1;
      next_st.cprot = 1'b0;
      next_st.gwp = 1'b0;
      next_st.dbg = 1'b0;
      next_st.pins = 2'h3;
      next_st.pins_bad = 1'b0;
      next_st.wdt = 1'b1;
      next_st.winoff = 1'b1;
      next_st.winact = 1'b0;
      next_st.pre = `CWL_PRE_128;
      next_st.post = 16'h8000;
      next_st.grant = 1'b0;
      next_st.rdata = `CWL_ERASED;
      next_st.rvalid = 1'b0;
      next_st.rpend = 1'b0;
      next_st.rprot = 1'b0;
      next_st.refused = 1'b0;
      next_st.erased = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign flash_rd = st.rd;
  assign flash_addr = st.addr;
  assign tbl_rdata = st.rdata;
  assign tbl_rvalid = st.rvalid;
  assign cfg_space_refused = st.refused;
  assign pm_write_grant = st.grant;
  assign dev_reset_hold = st.hold;
  assign config_word_one_valid = st.valid;
  assign config_word_one = st.w1;
  assign scan_port_enable = st.scan;
  assign general_code_protect = st.cprot;
  assign general_write_protect = st.gwp;
  assign debug_mode_entry = st.dbg;
  assign emulator_pin_pair_select = st.pins;
  assign emulator_pin_reserved = st.pins_bad;
  assign watchdog_on = st.wdt;
  assign window_mode_off = st.winoff;
  assign window_mode_active = st.winact;
  assign watchdog_prescale_ratio = st.pre;
  assign watchdog_postscale_ratio = st.post;
endmodule

// ---- cwl_loader_asserts.sv ----
`timescale 1ns/1ps
module cwl_loader_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched ports
  input wire logic dev_reset_req,
  input wire logic flash_rd,
  input wire logic [23:0] flash_addr,
  input wire logic flash_ack,
  input wire logic fetch_or_data,
  input wire logic [23:0] tbl_addr,
  input wire logic cfg_space_refused,
  input wire logic pm_write_req,
  input wire logic pm_write_grant,
  input wire logic dev_reset_hold,
  input wire logic config_word_one_valid,
  input wire cwl_pkg::cwl_word_t config_word_one,
  input wire logic general_write_protect,
  input wire logic window_mode_active,
  input wire logic [7:0] watchdog_prescale_ratio
);
  import cwl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // decodes lag the raw word, so compare against last cycle's word
  sequence settled;
    !dev_reset_hold && config_word_one_valid && $past(config_word_one_valid);
  endsequence
  hold_after_reset_a: assert property (
    $fell(srst) |-> dev_reset_hold && !config_word_one_valid)
    else $error("hold missing after reset");
  read_held_a: assert property (
    flash_rd && !flash_ack |=> flash_rd && $stable(flash_addr))
    else $error("flash read dropped early");
  release_valid_a: assert property ($fell(dev_reset_hold) |-> config_word_one_valid)
    else $error("hold released before load");
  reload_start_a: assert property (
    dev_reset_req && !dev_reset_hold |-> ##[1:3] dev_reset_hold)
    else $error("reload not started");
  space_refused_a: assert property (fetch_or_data && tbl_addr[23] |=> cfg_space_refused)
    else $error("config space fetch not refused");
  no_refuse_a: assert property (!(fetch_or_data && tbl_addr[23]) |=> !cfg_space_refused)
    else $error("spurious refusal");
  write_grant_a: assert property (
    pm_write_req && !dev_reset_hold |=> pm_write_grant == !$past(general_write_protect))
    else $error("write grant wrong");
  prescale_a: assert property (
    settled |-> watchdog_prescale_ratio == ($past(config_word_one[4]) ? 8'h80 : 8'h20))
    else $error("prescale wrong");
  window_a: assert property (
    settled |-> window_mode_active == $past(config_word_one[7] & ~config_word_one[6]))
    else $error("window mode wrong");
  cover property ($fell(dev_reset_hold));
  cover property (cfg_space_refused);
  cover property (pm_write_grant);
endmodule

// ---- cwl_flash_model.sv ----
`timescale 1ns/1ps
module cwl_flash_model (
  // clock
  input wire logic clk,
  // read port
  input wire logic flash_rd,
  input wire logic [23:0] flash_addr,
  output logic flash_ack,
  output cwl_pkg::cwl_word_t flash_data,
  // contents and pacing
  input wire logic [23:0] top_addr,
  input wire logic [2:0][23:0] words,
  input wire logic [3:0] delay
);
  logic [3:0] cnt = 4'h0;
  initial flash_ack = 1'b0;
  initial flash_data = 24'h0;
  always @(posedge clk) begin
    flash_ack <= 1'b0;
    // idle bus toggles so stale data never looks valid
    flash_data <= ~flash_data;
    if (flash_rd && !flash_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= delay) begin
        cnt <= 4'h0;
        flash_ack <= 1'b1;
        flash_data <= words[2'((top_addr - flash_addr) >> 1)];
      end
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "cwl_map.svh"
module tb_top;
  import cwl_pkg::*;
  logic clk = 1'b0, srst = 1'b1, dev_reset_req = 1'b0, page_erase_last = 1'b0;
  logic serial_prog_path = 1'b0, tbl_rd = 1'b0, tbl_wr = 1'b0, fetch_or_data = 1'b0;
  logic pm_write_req = 1'b0, was_hold = 1'b0;
  logic [23:0] tbl_addr = 24'h0, flash_addr;
  cwl_word_t tbl_wdata = 24'h0, flash_data, tbl_rdata, config_word_one, w;
  logic flash_rd, flash_ack, tbl_rvalid, cfg_space_refused, pm_write_grant, dev_reset_hold;
  logic config_word_one_valid, general_code_protect, debug_mode_entry, window_mode_active;
  logic scan_port_enable, general_write_protect, emulator_pin_reserved, watchdog_on, window_mode_off;
  logic [1:0] emulator_pin_pair_select;
  logic [7:0] watchdog_prescale_ratio;
  logic [15:0] watchdog_postscale_ratio;
  logic [2:0][23:0] words = '1;
  logic [3:0] delay = 4'h0;
  cwl_word_t exp_q[$];
  int n_errors = 0, num_checks = 0;
  always #50 clk = ~clk;
  cwl_loader dut (.clk, .srst, .dev_reset_req, .flash_rd, .flash_addr, .flash_ack, .flash_data,
    .page_erase_last, .serial_prog_path, .tbl_rd, .tbl_wr, .fetch_or_data, .tbl_addr, .tbl_wdata,
    .tbl_rdata, .tbl_rvalid, .cfg_space_refused, .pm_write_req, .pm_write_grant, .dev_reset_hold,
    .config_word_one_valid, .config_word_one, .scan_port_enable, .general_code_protect,
    .general_write_protect, .debug_mode_entry, .emulator_pin_pair_select,
    .emulator_pin_reserved, .watchdog_on, .window_mode_off, .window_mode_active,
    .watchdog_prescale_ratio, .watchdog_postscale_ratio);
  cwl_flash_model fm (.clk, .flash_rd, .flash_addr, .flash_ack, .flash_data,
    .top_addr(`CWL_TOP_WORD_DEF), .words, .delay);
  task automatic chk(string name, cwl_word_t seen, cwl_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic cwl_word_t pop();
    if (exp_q.size() == 0) return 24'hx;
    return exp_q.pop_front();
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    n_errors += exp_q.size();
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // table reads of word one always go through the base address
  task automatic tread(cwl_word_t e);
    tbl_addr = 24'hf80000;
    tbl_rd = 1'b1;
    exp_q.push_back(e);
    tick();
    tbl_rd = 1'b0;
    tick(2);
  endtask
  task automatic load(int k, bit by_req);
    w = {8'hff, 1'b0, 4'($urandom), 1'b1, 2'(k % 3 + 1), 2'($urandom), 1'b1, 1'($urandom), 4'(k)};
    words = {24'hff0000 | 24'($urandom), 24'hff0000 | 24'($urandom), w};
    delay = 4'($urandom);
    pm_write_req = 1'($urandom);
    exp_q.push_back(w);
    if (by_req) begin
      dev_reset_req = 1'b1;
      tick();
      dev_reset_req = 1'b0;
    end else begin
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      chk("reset word", config_word_one, 24'hffffff);
    end
    tick(3);
    for (int i = 0; i < 200 && dev_reset_hold; i++) tick();
    chk("prescale", 24'(watchdog_prescale_ratio), w[4] ? 24'h80 : 24'h20);
    chk("postscale", 24'(watchdog_postscale_ratio), 24'h1 << k);
    chk("pins", 24'(emulator_pin_pair_select), 24'(w[9:8]));
    chk("debug", 24'(debug_mode_entry), 24'(!w[11]));
    chk("code protect", 24'(general_code_protect), 24'(!w[13]));
    chk("scan", 24'(scan_port_enable), 24'(w[14]));
    chk("write protect", 24'(general_write_protect), 24'(!w[12]));
    chk("watchdog", 24'(watchdog_on), 24'(w[7]));
    chk("window off", 24'(window_mode_off), 24'(w[6]));
    tread(w[13] ? w | 24'hff0020 : 24'hffffff);
    tbl_addr = 24'($urandom);
    fetch_or_data = 1'b1;
    if (tbl_addr[23]) exp_q.push_back(24'h1);
    tick();
    fetch_or_data = 1'b0;
    tick(2);
  endtask
  always begin
    @(posedge clk);
    #2;
    if (tbl_rvalid) chk("table read", tbl_rdata, pop());
    if (cfg_space_refused) chk("refusal", 24'(cfg_space_refused), pop());
    if (was_hold && !dev_reset_hold) chk("loaded word", config_word_one, pop());
    was_hold = dev_reset_hold;
  end
  initial begin
    #(5000 * 100);
    n_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h0d6ee538));
    load(15, 0);
    for (int k = 0; k < 16; k++) load(k, 1);
    load(5, 0);
    for (int p = 0; p < 2; p++) begin
      serial_prog_path = p[0];
      tbl_addr = 24'hf80000;
      tbl_wdata = w ^ 24'h004000 ^ (p[0] ? {14'h0, w[9:8], 8'h0} : 24'h0);
      tbl_wr = 1'b1;
      tick();
      tbl_wr = 1'b0;
      tick(2);
      chk("scan bit", 24'(config_word_one[14]), 24'(w[14] ^ p[0]));
      chk("pin reserved", 24'(emulator_pin_reserved), 24'(p[0]));
    end
    page_erase_last = 1'b1;
    tick();
    page_erase_last = 1'b0;
    tick(2);
    chk("erase protect", 24'(general_code_protect), 24'h1);
    tread(24'hffffff);
    load(9, 1);
    wrap_up();
  end
endmodule
bind cwl_loader cwl_loader_asserts chk_i (.clk, .srst, .dev_reset_req, .flash_rd, .flash_addr,
  .flash_ack, .fetch_or_data, .tbl_addr, .cfg_space_refused, .pm_write_req, .pm_write_grant,
  .dev_reset_hold, .config_word_one_valid, .config_word_one, .general_write_protect,
  .window_mode_active, .watchdog_prescale_ratio);
